/* ftt_regs.vh */
// Behaviour
// - Flow alarm declared only after flow stays beyond a limit for 0..3600 s.
// - Without flow latch (default) the flow alarm drops once flow is back in limits.
// - Flow latch setting governs flow alarm outputs; when enabled they stay asserted.
// - High flow alarm output activates when flow reaches or exceeds the high flow limit.
// - Temperature alarm enable resets to disabled; disabled suppresses temperature alarms.
// - Temperature limits in 0.1 C steps from -9.9 to 99.9 C only.
// - Temperature alarm condition holds at or above high, or at or below low.
// - Low temperature alarm output activates when temperature falls to or below the low limit.
// - High temperature alarm output activates when temperature reaches or exceeds the high limit.
// - Temperature alarm declared only after the condition persists for 0..3600 s.
// - Temperature latch resets disabled; enabled keeps the temperature alarm outputs on.
// - Total integrates flow, is saved every second and reloaded at power-up.
// - Main totalizer enable defaults to disabled; no accumulation while disabled.
// - No accumulation until flow is at or above the start threshold.
// - Start threshold in 0.1 percent steps from 0.0 to 100.0 percent.
// - Event raised when total equals event volume; zero volume disables it.
// - Reset needs two presses within 2 s; acknowledgement then shows for 2 s.
// - Flow alarm condition holds at or above high, or at or below low.
// - Low flow alarm output activates when flow drops to or below the low limit.
`ifndef FTT_REGS_VH
`define FTT_REGS_VH
`define FTT_CLK_KHZ 10000
`define FTT_TICK_MS 1000
`define FTT_WIN_MS 2000
`define FTT_TICK_CYC (`FTT_TICK_MS * `FTT_CLK_KHZ)
`define FTT_WIN_CYC (`FTT_WIN_MS * `FTT_CLK_KHZ)
`define FTT_DLY_MAX 12'hE10
`define FTT_PCT_MAX 10'h3E8
`define FTT_TEMP_MIN 11'h79D
`define FTT_TEMP_MAX 11'h3E7
`define FTT_OFF_CTRL 8'h00
`define FTT_OFF_FLIM 8'h04
`define FTT_OFF_TLIM 8'h08
`define FTT_OFF_FDLY 8'h0C
`define FTT_OFF_TDLY 8'h10
`define FTT_OFF_START 8'h14
`define FTT_OFF_EVOL 8'h18
`define FTT_OFF_CMD 8'h1C
`define FTT_OFF_STAT 8'h20
`define FTT_OFF_TOTAL 8'h24
`define FTT_CTRL_FEN 0
`define FTT_CTRL_FLATCH 1
`define FTT_CTRL_TEN 2
`define FTT_CTRL_TLATCH 3
`define FTT_CTRL_TOTEN 4
`define FTT_CTRL_CLR 8
`define FTT_CTRL_RST 5'h00
`define FTT_LIM_HI_LSB 16
`define FTT_RESP_OKAY 2'h0
`define FTT_RESP_SLVERR 2'h2
`endif

/* ftt_tick.v */
`timescale 1ns/10ps
`default_nettype none
module ftt_tick #(
    parameter CW = 24,
    parameter [CW-1:0] PERIOD = 24'h989680
) (
    input wire clk_i,
    input wire rst_i,
    output reg tick_o
);
    reg [CW-1:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q == PERIOD - 1'b1) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // ftt_tick
`default_nettype wire

/* ftt_alarm.v */
`timescale 1ns/10ps
`default_nettype none
module ftt_alarm #(
    parameter W = 11,
    parameter DW = 12
) (
    input wire clk_i,
    input wire rst_i,
    input wire tick_i,
    input wire en_i,
    input wire latch_i,
    input wire clr_i,
    input wire signed [W-1:0] val_i,
    input wire signed [W-1:0] hi_lim_i,
    input wire signed [W-1:0] lo_lim_i,
    input wire [DW-1:0] delay_i,
    output reg hi_o,
    output reg lo_o
);
    reg [DW-1:0] hi_cnt_q;
    reg [DW-1:0] lo_cnt_q;
    wire hi_cond;
    wire lo_cond;
    wire hi_qual;
    wire lo_qual;

    // Counting saturates at the delay so a long violation never wraps back to zero.
    function [DW-1:0] cnt_next;
        input [DW-1:0] c;
        input cond;
        input tk;
        input [DW-1:0] d;
        begin
            if (!cond)
                cnt_next = {DW{1'b0}};
            else if (tk && c < d)
                cnt_next = c + 1'b1;
            else
                cnt_next = c;
        end
    endfunction

    assign hi_cond = en_i & (val_i >= hi_lim_i);
    assign lo_cond = en_i & (val_i <= lo_lim_i);
    assign hi_qual = hi_cond & (hi_cnt_q >= delay_i);
    assign lo_qual = lo_cond & (lo_cnt_q >= delay_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            hi_cnt_q <= {DW{1'b0}};
            lo_cnt_q <= {DW{1'b0}};
            hi_o <= 1'b0;
            lo_o <= 1'b0;
        end else begin
            hi_cnt_q <= cnt_next(hi_cnt_q, hi_cond, tick_i, delay_i);
            lo_cnt_q <= cnt_next(lo_cnt_q, lo_cond, tick_i, delay_i);
            hi_o <= hi_qual | (latch_i & hi_o & ~clr_i);
            lo_o <= lo_qual | (latch_i & lo_o & ~clr_i);
        end
    end
endmodule // ftt_alarm
`default_nettype wire

/* ftt_top.v */
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ftt_regs.vh"
module ftt_top #(
    parameter TICK_CYC = `FTT_TICK_CYC,
    parameter WIN_CYC = `FTT_WIN_CYC,
    parameter TW = 32
) (
    // Clock and reset.
    input wire REF_CLK_I,
    input wire SRST_I,
    // Measurements, flow in 0.1 percent of full scale, temperature in signed 0.1 C.
    input wire [9:0] FLOW_RATE_I,
    input wire [10:0] TEMP_I,
    // Keypad and nonvolatile store.
    input wire RESET_PRESS_I,
    input wire [TW-1:0] NV_TOTAL_I,
    output reg NV_SAVE_O,
    output reg [TW-1:0] NV_DATA_O,
    // Indicators and isolated outputs.
    output wire HIGH_ALARM_INDICATOR_O,
    output wire LOW_FLOW_ALARM_O,
    output wire TEMP_HIGH_ALARM_O,
    output wire TEMP_LOW_ALARM_O,
    output reg TOTAL_EVENT_O,
    output reg RESET_CONFIRM_O,
    output reg RESET_ACK_O,
    output reg [TW-1:0] MAIN_TOTAL_READOUT_O,
    // AXI4-Lite write channels.
    input wire [7:0] AXI_AWADDR_I,
    input wire AXI_AWVALID_I,
    output reg AXI_AWREADY_O,
    input wire [31:0] AXI_WDATA_I,
    input wire [3:0] AXI_WSTRB_I,
    input wire AXI_WVALID_I,
    output reg AXI_WREADY_O,
    output reg [1:0] AXI_BRESP_O,
    output reg AXI_BVALID_O,
    input wire AXI_BREADY_I,
    // AXI4-Lite read channels.
    input wire [7:0] AXI_ARADDR_I,
    input wire AXI_ARVALID_I,
    output reg AXI_ARREADY_O,
    output reg [31:0] AXI_RDATA_O,
    output reg [1:0] AXI_RRESP_O,
    output reg AXI_RVALID_O,
    input wire AXI_RREADY_I
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONF = 3'b010;
    localparam ST_ACK = 3'b100;
    localparam [24:0] WIN_END = WIN_CYC[24:0] - 25'h0000001;
    localparam [23:0] TICK_P = TICK_CYC[23:0];

    reg [4:0] ctrl_q;
    reg clr_q;
    reg press_q;
    reg [9:0] flo_lo_q;
    reg [9:0] flo_hi_q;
    reg [10:0] t_lo_q;
    reg [10:0] t_hi_q;
    reg [11:0] fdly_q;
    reg [11:0] tdly_q;
    reg [9:0] start_q;
    reg [TW-1:0] evol_q;
    reg load_q;
    reg [2:0] st_q;
    reg [24:0] win_q;
    reg aw_have_q;
    reg [7:0] aw_addr_q;
    reg w_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [31:0] rd_word;
    reg rd_ok;
    wire tick;
    wire press;
    wire do_wr;
    wire [31:0] cur;
    wire [31:0] mw;
    wire [31:0] status;

    // Byte lanes not strobed keep their previous contents.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    function temp_ok;
        input [10:0] v;
        begin
            temp_ok = ($signed(v) >= $signed(`FTT_TEMP_MIN)) && ($signed(v) <= $signed(`FTT_TEMP_MAX));
        end
    endfunction

    function [11:0] dly_clip;
        input [11:0] v;
        begin
            dly_clip = (v > `FTT_DLY_MAX) ? `FTT_DLY_MAX : v;
        end
    endfunction

    function [9:0] pct_clip;
        input [9:0] v;
        begin
            pct_clip = (v > `FTT_PCT_MAX) ? `FTT_PCT_MAX : v;
        end
    endfunction

    ftt_tick #(
        .CW(24),
        .PERIOD(TICK_P)
    ) u_tick (
        .clk_i(REF_CLK_I),
        .rst_i(SRST_I),
        .tick_o(tick)
    );

    ftt_alarm #(
        .W(11),
        .DW(12)
    ) u_flow (
        .clk_i(REF_CLK_I),
        .rst_i(SRST_I),
        .tick_i(tick),
        .en_i(ctrl_q[`FTT_CTRL_FEN]),
        .latch_i(ctrl_q[`FTT_CTRL_FLATCH]),
        .clr_i(clr_q),
        .val_i({1'b0, FLOW_RATE_I}),
        .hi_lim_i({1'b0, flo_hi_q}),
        .lo_lim_i({1'b0, flo_lo_q}),
        .delay_i(fdly_q),
        .hi_o(HIGH_ALARM_INDICATOR_O),
        .lo_o(LOW_FLOW_ALARM_O)
    );

    ftt_alarm #(
        .W(11),
        .DW(12)
    ) u_temp (
        .clk_i(REF_CLK_I),
        .rst_i(SRST_I),
        .tick_i(tick),
        .en_i(ctrl_q[`FTT_CTRL_TEN]),
        .latch_i(ctrl_q[`FTT_CTRL_TLATCH]),
        .clr_i(clr_q),
        .val_i(TEMP_I),
        .hi_lim_i(t_hi_q),
        .lo_lim_i(t_lo_q),
        .delay_i(tdly_q),
        .hi_o(TEMP_HIGH_ALARM_O),
        .lo_o(TEMP_LOW_ALARM_O)
    );

    assign press = RESET_PRESS_I | press_q;
    assign do_wr = aw_have_q & w_have_q & ~AXI_BVALID_O;
    assign status = {25'h0000000, RESET_ACK_O, RESET_CONFIRM_O, TOTAL_EVENT_O,
                     TEMP_LOW_ALARM_O, TEMP_HIGH_ALARM_O, LOW_FLOW_ALARM_O, HIGH_ALARM_INDICATOR_O};

    // Current contents of the addressed write target, used for byte-lane merging.
    assign cur = (aw_addr_q == `FTT_OFF_CTRL) ? {27'h0000000, ctrl_q} :
                 (aw_addr_q == `FTT_OFF_FLIM) ? {6'h00, flo_hi_q, 6'h00, flo_lo_q} :
                 (aw_addr_q == `FTT_OFF_TLIM) ? {5'h00, t_hi_q, 5'h00, t_lo_q} :
                 (aw_addr_q == `FTT_OFF_FDLY) ? {20'h00000, fdly_q} :
                 (aw_addr_q == `FTT_OFF_TDLY) ? {20'h00000, tdly_q} :
                 (aw_addr_q == `FTT_OFF_START) ? {22'h000000, start_q} :
                 (aw_addr_q == `FTT_OFF_EVOL) ? evol_q : 32'h00000000;
    assign mw = merge(cur, w_data_q, w_strb_q);

    always @* begin
        rd_ok = 1'b1;
        case (AXI_ARADDR_I)
            `FTT_OFF_CTRL: rd_word = {27'h0000000, ctrl_q};
            `FTT_OFF_FLIM: rd_word = {6'h00, flo_hi_q, 6'h00, flo_lo_q};
            `FTT_OFF_TLIM: rd_word = {5'h00, t_hi_q, 5'h00, t_lo_q};
            `FTT_OFF_FDLY: rd_word = {20'h00000, fdly_q};
            `FTT_OFF_TDLY: rd_word = {20'h00000, tdly_q};
            `FTT_OFF_START: rd_word = {22'h000000, start_q};
            `FTT_OFF_EVOL: rd_word = evol_q;
            `FTT_OFF_CMD: rd_word = 32'h00000000;
            `FTT_OFF_STAT: rd_word = status;
            `FTT_OFF_TOTAL: rd_word = MAIN_TOTAL_READOUT_O;
            default: begin
                rd_word = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Write side: address and data are taken independently, then committed together.
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            AXI_AWREADY_O <= 1'b1;
            AXI_WREADY_O <= 1'b1;
            AXI_BVALID_O <= 1'b0;
            AXI_BRESP_O <= `FTT_RESP_OKAY;
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            ctrl_q <= `FTT_CTRL_RST;
            clr_q <= 1'b0;
            press_q <= 1'b0;
            flo_lo_q <= 10'h000;
            flo_hi_q <= 10'h000;
            t_lo_q <= 11'h000;
            t_hi_q <= 11'h000;
            fdly_q <= 12'h000;
            tdly_q <= 12'h000;
            start_q <= 10'h000;
            evol_q <= {TW{1'b0}};
        end else begin
            clr_q <= 1'b0;
            press_q <= 1'b0;
            if (AXI_AWVALID_I && AXI_AWREADY_O) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= AXI_AWADDR_I;
                AXI_AWREADY_O <= 1'b0;
            end
            if (AXI_WVALID_I && AXI_WREADY_O) begin
                w_have_q <= 1'b1;
                w_data_q <= AXI_WDATA_I;
                w_strb_q <= AXI_WSTRB_I;
                AXI_WREADY_O <= 1'b0;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                AXI_BVALID_O <= 1'b1;
                AXI_BRESP_O <= `FTT_RESP_OKAY;
                case (aw_addr_q)
                    `FTT_OFF_CTRL: begin
                        ctrl_q <= mw[4:0];
                        clr_q <= mw[`FTT_CTRL_CLR] & w_strb_q[1];
                    end
                    `FTT_OFF_FLIM: begin
                        flo_lo_q <= pct_clip(mw[9:0]);
                        flo_hi_q <= pct_clip(mw[`FTT_LIM_HI_LSB +: 10]);
                    end
                    `FTT_OFF_TLIM: begin
                        // Out-of-range limits are dropped rather than clipped, keeping the old value.
                        if (temp_ok(mw[10:0]))
                            t_lo_q <= mw[10:0];
                        if (temp_ok(mw[`FTT_LIM_HI_LSB +: 11]))
                            t_hi_q <= mw[`FTT_LIM_HI_LSB +: 11];
                    end
                    `FTT_OFF_FDLY: fdly_q <= dly_clip(mw[11:0]);
                    `FTT_OFF_TDLY: tdly_q <= dly_clip(mw[11:0]);
                    `FTT_OFF_START: start_q <= pct_clip(mw[9:0]);
                    `FTT_OFF_EVOL: evol_q <= mw;
                    `FTT_OFF_CMD: press_q <= w_data_q[0] & w_strb_q[0];
                    `FTT_OFF_STAT: AXI_BRESP_O <= `FTT_RESP_OKAY;
                    `FTT_OFF_TOTAL: AXI_BRESP_O <= `FTT_RESP_OKAY;
                    default: AXI_BRESP_O <= `FTT_RESP_SLVERR;
                endcase
            end
            if (AXI_BVALID_O && AXI_BREADY_I) begin
                AXI_BVALID_O <= 1'b0;
                AXI_AWREADY_O <= 1'b1;
                AXI_WREADY_O <= 1'b1;
            end
        end
    end

    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O <= 1'b0;
            AXI_RDATA_O <= 32'h00000000;
            AXI_RRESP_O <= `FTT_RESP_OKAY;
        end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O <= 1'b1;
            AXI_RDATA_O <= rd_word;
            AXI_RRESP_O <= rd_ok ? `FTT_RESP_OKAY : `FTT_RESP_SLVERR;
        end else if (AXI_RVALID_O && AXI_RREADY_I) begin
            AXI_RVALID_O <= 1'b0;
            AXI_ARREADY_O <= 1'b1;
        end
    end

    // Two-press reset sequencer; presses during the acknowledgement are ignored.
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            st_q <= ST_IDLE;
            win_q <= 25'h0000000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    win_q <= 25'h0000000;
                    if (press)
                        st_q <= ST_CONF;
                end
                ST_CONF: begin
                    if (press) begin
                        st_q <= ST_ACK;
                        win_q <= 25'h0000000;
                    end else if (win_q == WIN_END) begin
                        st_q <= ST_IDLE;
                    end else begin
                        win_q <= win_q + 1'b1;
                    end
                end
                ST_ACK: begin
                    if (win_q == WIN_END)
                        st_q <= ST_IDLE;
                    else
                        win_q <= win_q + 1'b1;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // The saved total is taken one cycle after reset release, never under reset itself.
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            load_q <= 1'b1;
            MAIN_TOTAL_READOUT_O <= {TW{1'b0}};
            NV_SAVE_O <= 1'b0;
            NV_DATA_O <= {TW{1'b0}};
            TOTAL_EVENT_O <= 1'b0;
            RESET_CONFIRM_O <= 1'b0;
            RESET_ACK_O <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (load_q)
                MAIN_TOTAL_READOUT_O <= NV_TOTAL_I;
            else if (st_q == ST_CONF && press)
                MAIN_TOTAL_READOUT_O <= {TW{1'b0}};
            else if (tick && ctrl_q[`FTT_CTRL_TOTEN] && FLOW_RATE_I >= start_q)
                MAIN_TOTAL_READOUT_O <= MAIN_TOTAL_READOUT_O + {{(TW-10){1'b0}}, FLOW_RATE_I};
            NV_SAVE_O <= tick & ~load_q;
            NV_DATA_O <= MAIN_TOTAL_READOUT_O;
            TOTAL_EVENT_O <= (evol_q != {TW{1'b0}}) && (MAIN_TOTAL_READOUT_O == evol_q);
            RESET_CONFIRM_O <= (st_q == ST_CONF) & ~press;
            RESET_ACK_O <= (st_q == ST_ACK) | (st_q == ST_CONF && press);
        end
    end
endmodule // ftt_top
`default_nettype wire

/* ftt_nv_store.sv */
`timescale 1ns/10ps
`default_nettype none
module ftt_nv_store #(
    parameter logic [31:0] INIT = 32'h0000_1234
) (
    // Clock.
    input wire logic clk_i,
    // Save request from the block.
    input wire logic save_i,
    input wire logic [31:0] data_i,
    // Stored total offered at power-up.
    output var logic [31:0] total_o
);
    // The store keeps its contents through a reset of the block, as real nonvolatile memory would.
    initial total_o = INIT;
    always @(posedge clk_i) begin
        if (save_i) begin
            total_o <= data_i;
        end
    end
endmodule // ftt_nv_store
`default_nettype wire

/* ftt_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ftt_top_chk #(
    parameter TICK_CYC = 20,
    parameter WIN_CYC = 50,
    parameter TW = 32
) (
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    // Totalizer and keypad outputs.
    input wire logic NV_SAVE_O,
    input wire logic [TW-1:0] MAIN_TOTAL_READOUT_O,
    input wire logic TOTAL_EVENT_O,
    input wire logic RESET_CONFIRM_O,
    input wire logic RESET_ACK_O,
    // Bus handshakes.
    input wire logic AXI_AWVALID_I,
    input wire logic AXI_AWREADY_O,
    input wire logic AXI_WVALID_I,
    input wire logic AXI_WREADY_O,
    input wire logic AXI_BVALID_O,
    input wire logic AXI_ARVALID_I,
    input wire logic AXI_ARREADY_O,
    input wire logic AXI_RVALID_O
);
    logic [31:0] conf_q;
    logic [31:0] ack_q;
    logic [31:0] gap_q;
    logic seen_q;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SRST_I);

    // The first save after reset is not timed, since the tick divider restarts with reset.
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            conf_q <= 32'h0;
            ack_q <= 32'h0;
            gap_q <= 32'h0;
            seen_q <= 1'h0;
        end else begin
            conf_q <= RESET_CONFIRM_O ? conf_q + 32'h1 : 32'h0;
            ack_q <= RESET_ACK_O ? ack_q + 32'h1 : 32'h0;
            gap_q <= NV_SAVE_O ? 32'h0 : gap_q + 32'h1;
            seen_q <= seen_q | NV_SAVE_O;
        end
    end

    conf_len_a: assert property ($fell(RESET_CONFIRM_O) && !RESET_ACK_O |-> conf_q == WIN_CYC)
        else $error("confirm window length wrong");
    ack_len_a: assert property ($fell(RESET_ACK_O) |-> ack_q == WIN_CYC + 1)
        else $error("acknowledge length wrong");
    ack_cause_a: assert property ($rose(RESET_ACK_O) |-> $past(RESET_CONFIRM_O))
        else $error("acknowledge without open window");
    keypad_excl_a: assert property (!(RESET_CONFIRM_O && RESET_ACK_O))
        else $error("confirm and acknowledge together");
    total_clear_a: assert property ($rose(RESET_ACK_O) |-> ##[0:1] MAIN_TOTAL_READOUT_O == 32'h0)
        else $error("total not cleared by second press");
    save_gap_a: assert property (NV_SAVE_O && seen_q |-> gap_q == TICK_CYC - 1)
        else $error("save spacing wrong");
    total_hold_a: assert property ($changed(MAIN_TOTAL_READOUT_O) |->
        NV_SAVE_O || RESET_ACK_O || $past(SRST_I, 2) || $past(SRST_I, 3))
        else $error("total moved between ticks");
    write_resp_a: assert property (AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
        |=> !AXI_BVALID_O ##1 AXI_BVALID_O)
        else $error("write response timing wrong");
    read_resp_a: assert property (AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O && !AXI_ARREADY_O)
        else $error("read response timing wrong");

    cover property ($fell(RESET_CONFIRM_O) && !RESET_ACK_O);
    cover property ($rose(RESET_ACK_O));
    cover property ($rose(TOTAL_EVENT_O));
endmodule // ftt_top_chk

bind ftt_top ftt_top_chk #(.TICK_CYC(TICK_CYC), .WIN_CYC(WIN_CYC), .TW(TW)) ftt_top_chk_i (
    .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .NV_SAVE_O(NV_SAVE_O),
    .MAIN_TOTAL_READOUT_O(MAIN_TOTAL_READOUT_O), .TOTAL_EVENT_O(TOTAL_EVENT_O),
    .RESET_CONFIRM_O(RESET_CONFIRM_O), .RESET_ACK_O(RESET_ACK_O),
    .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O), .AXI_WVALID_I(AXI_WVALID_I),
    .AXI_WREADY_O(AXI_WREADY_O), .AXI_BVALID_O(AXI_BVALID_O), .AXI_ARVALID_I(AXI_ARVALID_I),
    .AXI_ARREADY_O(AXI_ARREADY_O), .AXI_RVALID_O(AXI_RVALID_O));
`default_nettype wire

/* ftt_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ftt_regs.vh"
module ftt_top_tb_top;
    localparam int TICK = 20;
    localparam int WIN = 50;
    localparam logic [31:0] NV_INIT = 32'h0000_1234;
    localparam logic [1:0] rs_ok = `FTT_RESP_OKAY;
    localparam logic [1:0] rs_err = `FTT_RESP_SLVERR;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic [9:0] flow = 10'h0;
    logic [10:0] temp = 11'h0;
    logic press = 1'h0;
    logic [31:0] nv_total;
    logic nv_save;
    logic [31:0] nv_data;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int fail_count = 0;
    int checks = 0;
    logic [31:0] tot;
    logic [9:0] f;

    always #50 clk = ~clk;

    ftt_top #(.TICK_CYC(TICK), .WIN_CYC(WIN), .TW(32)) ftt_top_i (
        .REF_CLK_I(clk), .SRST_I(srst), .FLOW_RATE_I(flow), .TEMP_I(temp), .RESET_PRESS_I(press),
        .NV_TOTAL_I(nv_total), .NV_SAVE_O(nv_save), .NV_DATA_O(nv_data), .HIGH_ALARM_INDICATOR_O(),
        .LOW_FLOW_ALARM_O(), .TEMP_HIGH_ALARM_O(), .TEMP_LOW_ALARM_O(), .TOTAL_EVENT_O(),
        .RESET_CONFIRM_O(), .RESET_ACK_O(), .MAIN_TOTAL_READOUT_O(),
        .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
        .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
        .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
        .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
        .AXI_RREADY_I(rready));

    ftt_nv_store #(.INIT(NV_INIT)) ftt_nv_store_i (
        .clk_i(clk), .save_i(nv_save), .data_i(nv_data), .total_o(nv_total));

    // Every bus answer is matched against the oldest expectation noted by the driver.
    always @(posedge clk) begin
        logic [33:0] e;
        if (rvalid && rready) begin
            e = rq.pop_front();
            checks = checks + 1;
            if ({rresp, rdata} !== e) begin
                fail_count = fail_count + 1;
                $display("BAD %0t read got %h %h want %h", $time, rresp, rdata, e);
            end
        end
        if (bvalid && bready) begin
            checks = checks + 1;
            if (bresp !== bq.pop_front()) begin
                fail_count = fail_count + 1;
                $display("BAD %0t write response %h", $time, bresp);
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        rq.push_back({er, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'h0;
        @(posedge clk);
    endtask

    // Returns just after the edge that ends a save pulse, so the next tick is 18 of the 20 cycles of a second away.
    task automatic ws(input int n);
        repeat (n) begin
            do @(posedge clk); while (!nv_save);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h62C4));
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        rd(`FTT_OFF_CTRL, 32'h0, rs_ok);
        rd(8'h40, 32'h0, rs_err);
        wr(8'h40, 32'h1, rs_err);
        wr(`FTT_OFF_TOTAL, 32'hFFFF_FFFF, rs_ok);
        rd(`FTT_OFF_TOTAL, NV_INIT, rs_ok);
        tot = NV_INIT;
        wr(`FTT_OFF_START, 32'h12C, rs_ok);
        flow <= 10'hC8;
        wr(`FTT_OFF_CTRL, 32'h10, rs_ok);
        ws(2);
        flow <= 10'h12C;
        rd(`FTT_OFF_TOTAL, tot, rs_ok);
        ws(2);
        tot = tot + 32'h258;
        for (int i = 0; i < 3; i++) begin
            f = 10'($urandom_range(799, 300));
            flow <= f;
            ws(1);
            tot = tot + 32'(f);
        end
        rd(`FTT_OFF_TOTAL, tot, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h0, rs_ok);
        ws(2);
        rd(`FTT_OFF_TOTAL, tot, rs_ok);
        wr(`FTT_OFF_EVOL, tot, rs_ok);
        rd(`FTT_OFF_STAT, 32'h10, rs_ok);
        wr(`FTT_OFF_EVOL, 32'h0, rs_ok);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        ws(1);
        srst <= 1'h1;
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        press <= 1'h1;
        @(posedge clk);
        press <= 1'h0;
        rd(`FTT_OFF_TOTAL, tot, rs_ok);
        rd(`FTT_OFF_STAT, 32'h20, rs_ok);
        repeat (WIN) @(posedge clk);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        rd(`FTT_OFF_TOTAL, tot, rs_ok);
        press <= 1'h1;
        @(posedge clk);
        press <= 1'h0;
        repeat (10) @(posedge clk);
        wr(`FTT_OFF_CMD, 32'h1, rs_ok);
        rd(`FTT_OFF_STAT, 32'h40, rs_ok);
        rd(`FTT_OFF_TOTAL, 32'h0, rs_ok);
        repeat (WIN + 2) @(posedge clk);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        wr(`FTT_OFF_FLIM, 32'h0320_0064, rs_ok);
        wr(`FTT_OFF_FDLY, 32'h2, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h1, rs_ok);
        ws(1);
        flow <= 10'h320;
        ws(1);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        flow <= 10'h1F4;
        ws(1);
        flow <= 10'h320;
        ws(1);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        ws(1);
        rd(`FTT_OFF_STAT, 32'h1, rs_ok);
        flow <= 10'h1F4;
        settle();
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        flow <= 10'h64;
        ws(2);
        rd(`FTT_OFF_STAT, 32'h2, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h3, rs_ok);
        flow <= 10'h1F4;
        settle();
        rd(`FTT_OFF_STAT, 32'h2, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h103, rs_ok);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        wr(`FTT_OFF_TLIM, 32'h01F4_07FB, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h0, rs_ok);
        temp <= 11'h1F4;
        settle();
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h4, rs_ok);
        settle();
        rd(`FTT_OFF_STAT, 32'h4, rs_ok);
        temp <= 11'h7FB;
        settle();
        rd(`FTT_OFF_STAT, 32'h8, rs_ok);
        wr(`FTT_OFF_CTRL, 32'hC, rs_ok);
        temp <= 11'h1F4;
        settle();
        temp <= 11'h64;
        settle();
        rd(`FTT_OFF_STAT, 32'hC, rs_ok);
        wr(`FTT_OFF_CTRL, 32'h10C, rs_ok);
        rd(`FTT_OFF_STAT, 32'h0, rs_ok);
        wr(`FTT_OFF_TLIM, 32'h03E8_07FB, rs_ok);
        temp <= 11'h258;
        settle();
        rd(`FTT_OFF_STAT, 32'h4, rs_ok);
        report_and_stop();
    end
endmodule // ftt_top_tb_top
`default_nettype wire
